/* core/charger_status_control_regs.sv */
// Purpose: charger status byte, control byte and charge sequencing
// Assumes: register port decoded from the serial interface, one clock
// Notes:   analog condition inputs are synchronised before use
`timescale 1ns/1ps
`default_nettype none
module charger_status_control_regs #(
  parameter int unsigned P_TICK_CYCLES = charger_regs_pkg::TICK_CYCLES
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  // register port
  input  wire logic [7:0] i_reg_addr,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  input  wire logic [7:0] i_reg_wdata,
  output logic      [7:0] o_reg_rdata,
  // analog condition levels
  input  wire logic       i_supply_ok,
  input  wire logic       i_die_hot,
  input  wire logic       i_path_limit,
  input  wire logic       i_batt_temp_bad,
  input  wire logic       i_no_thermistor,
  input  wire logic       i_batt_low,
  input  wire logic       i_end_current,
  // charger controls
  output logic            o_charge_drive,
  output logic            o_precharge_mode,
  output logic            o_thermistor_kind_select,
  output logic            o_charger_held_reset
);

  localparam int unsigned TW = charger_regs_pkg::TIMER_W;
  localparam logic [TW-1:0] PRE_LIMIT =
    TW'(charger_regs_pkg::PRECHARGE_MIN * charger_regs_pkg::SEC_PER_MIN);

  // synchronised conditions
  logic [6:0] cond_s;
  logic       supply_ok_s;
  logic       die_hot_s;
  logic       path_limit_s;
  logic       temp_bad_s;
  logic       no_therm_s;
  logic       batt_low_s;
  logic       end_current_s;

  // register state
  logic [7:0] control_q;
  logic [7:0] status_q;
  logic [7:0] status_d;

  // control fields
  logic [1:0] timer_sel;
  logic       safety_timers_enable;
  logic       thermistor_kind_select;
  logic       reset_bit;
  logic       term_off;
  logic       timers_hold;
  logic       charger_on;

  // sequencing
  charger_regs_pkg::charge_state_t state_q;
  charger_regs_pkg::charge_state_t state_d;
  logic        allowed;
  logic        temp_err;
  logic        charging;
  logic        pre_timed_out_q;
  logic        pre_timed_out_d;
  logic        pre_expired;
  logic        fast_expired;
  logic        pre_clear;
  logic        fast_clear;
  logic        pre_run;
  logic        fast_run;
  logic [TW-1:0] fast_limit;

  // second tick
  logic [31:0] tick_cnt_q;
  logic        tick;

  // register port decode
  logic        hit_status;
  logic        hit_control;
  logic        wr_control;
  logic [7:0]  rdata_d;

  // bring analog levels into the clock domain
  level_sync #(
    .WIDTH (7)
  ) u_cond_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_async   ({i_supply_ok, i_die_hot, i_path_limit, i_batt_temp_bad,
                 i_no_thermistor, i_batt_low, i_end_current}),
    .o_sync    (cond_s)
  );

  assign supply_ok_s   = cond_s[6];
  assign die_hot_s     = cond_s[5];
  assign path_limit_s  = cond_s[4];
  assign temp_bad_s    = cond_s[3];
  assign no_therm_s    = cond_s[2];
  assign batt_low_s    = cond_s[1];
  assign end_current_s = cond_s[0];

  // address decode
  assign hit_status  = (i_reg_addr == charger_regs_pkg::STATUS_ADDR);
  assign hit_control = (i_reg_addr == charger_regs_pkg::CONTROL_ADDR);
  assign wr_control  = i_reg_wr && hit_control;

  // control field split
  // fast timer select
  assign timer_sel              = control_q[charger_regs_pkg::CT_TIMER_HI:
                                            charger_regs_pkg::CT_TIMER_LO];
  assign safety_timers_enable   = control_q[charger_regs_pkg::CT_SAFETY_TIMERS_ENABLE];
  assign thermistor_kind_select = control_q[charger_regs_pkg::CT_THERM_KIND];
  assign reset_bit              = control_q[charger_regs_pkg::CT_RESET];
  assign term_off               = control_q[charger_regs_pkg::CT_TERM_OFF];
  assign timers_hold            = control_q[charger_regs_pkg::CT_HOLD];
  assign charger_on             = control_q[charger_regs_pkg::CT_ON];

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      control_q <= charger_regs_pkg::CONTROL_RESET;
    end else if (wr_control) begin
      control_q <= i_reg_wdata;
    end
  end

  // read mux, unmapped offsets read zero
  // reads only select data
  always_comb begin
    if (hit_status) begin
      rdata_d = status_q;
    end else if (hit_control) begin
      rdata_d = control_q;
    end else begin
      rdata_d = 8'h00;
    end
  end

  // read data register
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_d;
    end
  end

  // once-per-second tick for the timers
  assign tick = (tick_cnt_q == 32'(P_TICK_CYCLES - 1));

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt_q <= 32'h0000_0000;
    end else if (tick) begin
      tick_cnt_q <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
    end
  end

  assign allowed  = charger_on && !reset_bit && supply_ok_s;
  assign temp_err = temp_bad_s || no_therm_s;
  assign charging = (state_q == charger_regs_pkg::CS_PRE) ||
                    (state_q == charger_regs_pkg::CS_FAST);

  // charge sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      charger_regs_pkg::CS_IDLE: begin
        if (allowed) begin
          if (temp_err) begin
            state_d = charger_regs_pkg::CS_HOLD;
          end else if (batt_low_s) begin
            state_d = charger_regs_pkg::CS_PRE;
          end else begin
            state_d = charger_regs_pkg::CS_FAST;
          end
        end
      end
      charger_regs_pkg::CS_PRE: begin
        if (!allowed) begin
          state_d = charger_regs_pkg::CS_IDLE;
        end else if (pre_expired) begin
          state_d = charger_regs_pkg::CS_TIMEOUT;
        end else if (temp_err) begin
          state_d = charger_regs_pkg::CS_HOLD;
        end else if (!batt_low_s) begin
          state_d = charger_regs_pkg::CS_FAST;
        end
      end
      charger_regs_pkg::CS_FAST: begin
        if (!allowed) begin
          state_d = charger_regs_pkg::CS_IDLE;
        end else if (fast_expired) begin
          state_d = charger_regs_pkg::CS_TIMEOUT;
        end else if (temp_err) begin
          state_d = charger_regs_pkg::CS_HOLD;
        end else if (end_current_s && !term_off) begin
          state_d = charger_regs_pkg::CS_DONE;
        end
      end
      charger_regs_pkg::CS_HOLD: begin
        if (!allowed) begin
          state_d = charger_regs_pkg::CS_IDLE;
        end else if (!temp_err) begin
          state_d = batt_low_s ? charger_regs_pkg::CS_PRE : charger_regs_pkg::CS_FAST;
        end
      end
      default: begin
        // done and time-out leave only through disable, reset or supply loss
        if (!allowed) begin
          state_d = charger_regs_pkg::CS_IDLE;
        end
      end
    endcase
  end

  // remember which timer ended the charge
  always_comb begin
    pre_timed_out_d = pre_timed_out_q;
    if (state_q == charger_regs_pkg::CS_IDLE) begin
      pre_timed_out_d = 1'b0;
    end else if (state_q == charger_regs_pkg::CS_PRE &&
                 state_d == charger_regs_pkg::CS_TIMEOUT) begin
      pre_timed_out_d = 1'b1;
    end
  end

  // state registers
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      state_q         <= charger_regs_pkg::CS_IDLE;
      pre_timed_out_q <= 1'b0;
    end else begin
      state_q         <= state_d;
      pre_timed_out_q <= pre_timed_out_d;
    end
  end

  assign pre_clear  = !allowed || !safety_timers_enable ||
                      (state_q == charger_regs_pkg::CS_FAST);
  assign fast_clear = !allowed || !safety_timers_enable ||
                      (state_q == charger_regs_pkg::CS_IDLE);
  assign pre_run    = (state_q == charger_regs_pkg::CS_PRE) && !timers_hold;
  assign fast_run   = (state_q == charger_regs_pkg::CS_FAST) && !timers_hold;
  assign fast_limit = charger_regs_pkg::fast_limit_sec(timer_sel);

  // precharge safety timer
  charge_timer #(
    .W (TW)
  ) u_pre_timer (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_clear   (pre_clear),
    .i_run     (pre_run),
    .i_tick    (tick),
    .i_limit   (PRE_LIMIT),
    .o_expired (pre_expired)
  );

  // fast-charge safety timer
  charge_timer #(
    .W (TW)
  ) u_fast_timer (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_clear   (fast_clear),
    .i_run     (fast_run),
    .i_tick    (tick),
    .i_limit   (fast_limit),
    .o_expired (fast_expired)
  );

  // status byte from live conditions
  always_comb begin
    status_d = charger_regs_pkg::STATUS_RESET;
    status_d[charger_regs_pkg::ST_DIE_HEAT]   = charging && die_hot_s;
    status_d[charger_regs_pkg::ST_PATH_LIMIT] = charging && path_limit_s;
    status_d[charger_regs_pkg::ST_HEAT_HOLD]  = (state_q == charger_regs_pkg::CS_HOLD);
    status_d[charger_regs_pkg::ST_END_CUR]    = (state_q == charger_regs_pkg::CS_DONE);
    status_d[charger_regs_pkg::ST_ACTIVE]     = charging;
    status_d[charger_regs_pkg::ST_TMR_EXP]    = (state_q == charger_regs_pkg::CS_TIMEOUT);
    status_d[charger_regs_pkg::ST_PRE_EXP]    =
      (state_q == charger_regs_pkg::CS_TIMEOUT) && pre_timed_out_q;
    status_d[charger_regs_pkg::ST_TEMP_ERR]   = temp_err;
  end

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      status_q <= charger_regs_pkg::STATUS_RESET;
    end else begin
      status_q <= status_d;
    end
  end

  // registered charger controls
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_charge_drive           <= 1'b0;
      o_precharge_mode         <= 1'b0;
      o_thermistor_kind_select <= 1'b1;
      o_charger_held_reset     <= 1'b0;
    end else begin
      o_charge_drive           <= (state_d == charger_regs_pkg::CS_PRE) ||
                                  (state_d == charger_regs_pkg::CS_FAST);
      o_precharge_mode         <= (state_d == charger_regs_pkg::CS_PRE);
      o_thermistor_kind_select <= thermistor_kind_select;
      o_charger_held_reset     <= reset_bit;
    end
  end

endmodule : charger_status_control_regs
`default_nettype wire

/* core/charger_regs_pkg.sv */
// Purpose: shared constants and types for the charger status/control bank
// Assumes: 100 MHz system clock, 8-bit register port
// Notes:   timer lengths are kept in hours and minutes; fast-charge seconds derived here, precharge in the top module
package charger_regs_pkg;

  // register offsets and values after reset
  localparam logic [7:0] STATUS_ADDR   = 8'h03;
  localparam logic [7:0] CONTROL_ADDR  = 8'h04;
  localparam logic [7:0] STATUS_RESET  = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'hB1;

  // status field positions
  localparam int unsigned ST_DIE_HEAT   = 7;
  localparam int unsigned ST_PATH_LIMIT = 6;
  localparam int unsigned ST_HEAT_HOLD  = 5;
  localparam int unsigned ST_END_CUR    = 4;
  localparam int unsigned ST_ACTIVE     = 3;
  localparam int unsigned ST_TMR_EXP    = 2;
  localparam int unsigned ST_PRE_EXP    = 1;
  localparam int unsigned ST_TEMP_ERR   = 0;

  // control field positions
  localparam int unsigned CT_TIMER_HI   = 7;
  localparam int unsigned CT_TIMER_LO   = 6;
  localparam int unsigned CT_SAFETY_TIMERS_ENABLE     = 5;
  localparam int unsigned CT_THERM_KIND = 4;
  localparam int unsigned CT_RESET      = 3;
  localparam int unsigned CT_TERM_OFF   = 2;
  localparam int unsigned CT_HOLD       = 1;
  localparam int unsigned CT_ON         = 0;

  // timer base: one tick per second
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_TIME_NS  = 1000000000;
  localparam int unsigned TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned SEC_PER_HOUR  = 3600;
  localparam int unsigned SEC_PER_MIN   = 60;

  // fast-charge lengths in hours, precharge length in minutes
  localparam int unsigned FAST_HOURS_00 = 4;
  localparam int unsigned FAST_HOURS_01 = 5;
  localparam int unsigned FAST_HOURS_10 = 6;
  localparam int unsigned FAST_HOURS_11 = 8;
  localparam int unsigned PRECHARGE_MIN = 30;
  localparam int unsigned TIMER_W       = 16;

  typedef enum logic [2:0] {
    CS_IDLE, CS_PRE, CS_FAST, CS_HOLD, CS_DONE, CS_TIMEOUT
  } charge_state_t;

  // fast-charge limit in seconds from the two select bits
  function automatic logic [TIMER_W-1:0] fast_limit_sec(input logic [1:0] sel);
    int unsigned hours;
    case (sel)
      2'h0:    hours = FAST_HOURS_00;
      2'h1:    hours = FAST_HOURS_01;
      2'h2:    hours = FAST_HOURS_10;
      default: hours = FAST_HOURS_11;
    endcase
    return TIMER_W'(hours * SEC_PER_HOUR);
  endfunction : fast_limit_sec

endpackage : charger_regs_pkg

/* core/level_sync.sv */
// Purpose: two-stage synchroniser for analog condition levels
// Assumes: inputs are slow levels from outside the clock domain
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;

  // two flip-flops in series
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule : level_sync
`default_nettype wire

/* core/charge_timer.sv */
// Purpose: seconds counter with hold, clear and sticky expiry
// Assumes: i_tick is a one-cycle pulse once per second
// Notes:   expiry stays set until cleared
`timescale 1ns/1ps
`default_nettype none
module charge_timer #(
  parameter int unsigned W = 16
) (
  input  wire logic         i_clk_sys,
  input  wire logic         i_rst,
  input  wire logic         i_clear,
  input  wire logic         i_run,
  input  wire logic         i_tick,
  input  wire logic [W-1:0] i_limit,
  output logic              o_expired
);

  logic [W-1:0] count_q;
  logic [W-1:0] count_inc;
  logic         step;

  assign step      = i_run && i_tick && !o_expired;
  assign count_inc = count_q + W'(1);

  // count elapsed seconds while running
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      count_q   <= '0;
      o_expired <= 1'b0;
    end else if (i_clear) begin
      count_q   <= '0;
      o_expired <= 1'b0;
    end else if (step) begin
      count_q   <= count_inc;
      o_expired <= (count_inc >= i_limit);
    end
  end

endmodule : charge_timer
`default_nettype wire

/* verif/charger_regs_checker_assertions.sv */
// Purpose: port assertions for the charger register bank
// Assumes: one clock, async active-high reset
// Notes:   bound to the design top module
`timescale 1ns/1ps
`default_nettype none
module charger_regs_checker (
  input wire logic       i_clk_sys,
  input wire logic       i_rst,
  input wire logic [7:0] i_reg_addr,
  input wire logic       i_reg_wr,
  input wire logic       i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       i_supply_ok,
  input wire logic       o_charge_drive,
  input wire logic       o_precharge_mode,
  input wire logic       o_thermistor_kind_select,
  input wire logic       o_charger_held_reset
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // read port behaviour
  a_rdata_holds: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (i_reg_rd && i_reg_addr != 8'h03 && i_reg_addr != 8'h04
    |=> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
  a_status_active: assert property (i_reg_rd && i_reg_addr == 8'h03
    |=> o_reg_rdata[3] == $past(o_charge_drive, 2)) else $error("active bit off drive");
  // control copies on outputs
  a_kind_follows: assert property (i_reg_wr && i_reg_addr == 8'h04
    |=> ##1 o_thermistor_kind_select == $past(i_reg_wdata[4], 2)) else $error("kind bad");
  a_held_follows: assert property (i_reg_wr && i_reg_addr == 8'h04
    |=> ##1 o_charger_held_reset == $past(i_reg_wdata[3], 2)) else $error("held bad");
  // charger stops when held or without supply
  a_held_no_drive: assert property (o_charger_held_reset [*3] |-> !o_charge_drive)
    else $error("drive while held in reset");
  a_supply_low_idle: assert property (!i_supply_ok [*5] |-> !o_charge_drive)
    else $error("drive without supply");
  a_pre_drives: assert property (o_precharge_mode |-> o_charge_drive)
    else $error("precharge without drive");
endmodule : charger_regs_checker
bind charger_status_control_regs charger_regs_checker charger_regs_checker_inst (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .i_supply_ok(i_supply_ok), .o_charge_drive(o_charge_drive),
  .o_precharge_mode(o_precharge_mode), .o_thermistor_kind_select(o_thermistor_kind_select),
  .o_charger_held_reset(o_charger_held_reset));
`default_nettype wire

/* verif/host_model.sv */
// Purpose: host side of the register port
// Assumes: strobes are taken on the rising edge
// Notes:   released lines show the inverse of their last value
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic       i_clk_sys,
  input  wire logic [7:0] i_rdata,
  output logic      [7:0] o_addr,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_wdata
);
  initial begin
    o_addr = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = 8'h00;
  end
  // one-cycle write strobe launched off the falling edge
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk_sys);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk_sys);
    o_wr = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
  endtask : write_reg
  // one-cycle read strobe, data taken after the edge
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_clk_sys);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk_sys);
    o_rd = 1'b0;
    o_addr = ~a;
    d = i_rdata;
  endtask : read_reg
  // restart: set the reset bit, then clear it
  task automatic restart(input logic [7:0] d);
    write_reg(8'h04, d | 8'h08);
    write_reg(8'h04, d & 8'hF7);
  endtask : restart
endmodule : host_model
`default_nettype wire

/* verif/tb_top.sv */
// Purpose: self-checking bench for the charger register bank
// Assumes: timer second shortened to two clocks
// Notes:   expected status comes from a small state model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       i_clk_sys = 1'b0;
  logic       i_rst     = 1'b1;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd, v;
  logic       reg_wr, reg_rd, drive, pre_mode, kind, held;
  logic       supply, die_hot, path_lim, temp_bad, no_therm, batt_low, end_cur;
  int         bad_count = 0;
  int         samples_checked = 0;
  int         mstate = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  host_model host_model_inst (.i_clk_sys(i_clk_sys), .i_rdata(reg_rdata), .o_addr(reg_addr),
    .o_wr(reg_wr), .o_rd(reg_rd), .o_wdata(reg_wdata));
  charger_status_control_regs #(.P_TICK_CYCLES(2)) charger_status_control_regs_inst (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_reg_addr(reg_addr), .i_reg_wr(reg_wr),
    .i_reg_rd(reg_rd), .i_reg_wdata(reg_wdata), .o_reg_rdata(reg_rdata),
    .i_supply_ok(supply), .i_die_hot(die_hot), .i_path_limit(path_lim),
    .i_batt_temp_bad(temp_bad), .i_no_thermistor(no_therm), .i_batt_low(batt_low),
    .i_end_current(end_cur), .o_charge_drive(drive), .o_precharge_mode(pre_mode),
    .o_thermistor_kind_select(kind), .o_charger_held_reset(held));
  // expected status: 0 idle, 1 charging, 2 done, 3 pre timeout, 4 fast timeout, 5 hold
  function automatic logic [7:0] exp_st();
    logic [7:0] s;
    case (mstate)
      1: s = {die_hot, path_lim, 6'h08};
      2: s = 8'h10;
      3: s = 8'h06;
      4: s = 8'h04;
      5: s = 8'h20;
      default: s = 8'h00;
    endcase
    s[0] = temp_bad | no_therm;
    return s;
  endfunction : exp_st
  task automatic conclude();
    if (bad_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
    host_model_inst.read_reg(a, rd);
    check(rd, exp);
  endtask : chk_reg
  // let inputs cross the synchroniser, then compare status
  task automatic chk_st();
    repeat (5) @(negedge i_clk_sys);
    chk_reg(8'h03, exp_st());
  endtask : chk_st
  task automatic wr_ctl(input logic [7:0] d);
    host_model_inst.write_reg(8'h04, d);
  endtask : wr_ctl
  // poll status until it matches, bounded
  task automatic wait_st(input int n);
    int i;
    for (i = 0; i < n; i++) begin
      host_model_inst.read_reg(8'h03, rd);
      if (rd === exp_st())
        break;
    end
    check(rd, exp_st());
    if (i == n)
      conclude();
  endtask : wait_st
  // main sequence
  initial begin
    void'($urandom(59797));
    {supply, die_hot, path_lim, temp_bad, no_therm, batt_low, end_cur} = 7'h00;
    repeat (5) @(negedge i_clk_sys);
    i_rst = 1'b0;
    chk_reg(8'h03, 8'h00);
    chk_reg(8'h04, 8'hB1);
    check({7'h00, kind}, 8'h01);
    // random control bytes, writes to status and unmapped reads
    for (int k = 0; k < 6; k++) begin
      v = 8'($urandom());
      wr_ctl(v);
      host_model_inst.write_reg(8'h03, ~v);
      chk_reg(8'h04, v);
      check({6'h00, kind, held}, {6'h00, v[4], v[3]});
      chk_reg(8'h03, 8'h00);
      chk_reg(8'h80 | v, 8'h00);
    end
    wr_ctl(8'hB1);
    supply = 1'b1;
    mstate = 1;
    chk_st();
    die_hot = 1'b1;
    chk_st();
    path_lim = 1'b1;
    chk_st();
    chk_st();
    {die_hot, path_lim} = 2'h0;
    // charger off, then on again
    wr_ctl(8'hB0);
    mstate = 0;
    chk_st();
    check({6'h00, drive, pre_mode}, 8'h00);
    wr_ctl(8'hB1);
    mstate = 1;
    chk_st();
    // end current with and without termination suppressed
    wr_ctl(8'hB5);
    end_cur = 1'b1;
    chk_st();
    wr_ctl(8'hB1);
    mstate = 2;
    chk_st();
    end_cur = 1'b0;
    wr_ctl(8'hB9);
    mstate = 0;
    chk_st();
    wr_ctl(8'hB1);
    mstate = 1;
    chk_st();
    // supply loss stops charging, its return restarts it
    supply = 1'b0;
    mstate = 0;
    chk_st();
    check({6'h00, drive, pre_mode}, 8'h00);
    supply = 1'b1;
    mstate = 1;
    chk_st();
    // temperature faults
    temp_bad = 1'b1;
    mstate = 5;
    chk_st();
    {temp_bad, no_therm} = 2'h1;
    chk_st();
    no_therm = 1'b0;
    mstate = 1;
    chk_st();
    // precharge timer: disabled, frozen, then running to expiry
    batt_low = 1'b1;
    host_model_inst.restart(8'h91);
    chk_st();
    check({7'h00, pre_mode}, 8'h01);
    repeat (5000) @(negedge i_clk_sys);
    chk_st();
    // part-run the timer, then freeze it: a kept count ends the charge early
    wr_ctl(8'hB1);
    repeat (2000) @(negedge i_clk_sys);
    chk_st();
    wr_ctl(8'hB3);
    repeat (5000) @(negedge i_clk_sys);
    chk_st();
    wr_ctl(8'hB1);
    mstate = 3;
    wait_st(1000);
    // fast timer at the 4h setting
    batt_low = 1'b0;
    host_model_inst.restart(8'h31);
    mstate = 1;
    repeat (28400) @(negedge i_clk_sys);
    chk_st();
    // past the 4h count, the longer settings must not end the charge
    wr_ctl(8'hF1);
    repeat (600) @(negedge i_clk_sys);
    chk_st();
    wr_ctl(8'h71);
    chk_st();
    wr_ctl(8'hB1);
    chk_st();
    wr_ctl(8'h31);
    mstate = 4;
    wait_st(300);
    // second reset in mid-run, supply gone so status stays quiet
    supply = 1'b0;
    wr_ctl(8'h4A);
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    i_rst = 1'b0;
    mstate = 0;
    chk_reg(8'h04, 8'hB1);
    check({6'h00, kind, held}, 8'h02);
    chk_st();
    conclude();
  end
endmodule : tb_top
`default_nettype wire
